// *** common/lcel_pkg.sv ***
package lcel_pkg;
  // Register pages, compared against paddr[39:32]
  localparam logic [39:0] EN_OFS = 40'haa_0000_0000;
  localparam logic [39:0] EN_ALT_OFS = 40'hba_0000_0000;
  localparam logic [39:0] ST_OFS = 40'hab_0000_0000;
  localparam logic [39:0] ST_ALT_OFS = 40'hbb_0000_0000;
  localparam logic [39:0] ADDR_OFS = 40'hac_0000_0000;
  // Enable register fields
  localparam int EN_DBG = 2;
  localparam int EN_NCEEN = 1;
  localparam int EN_CEEN = 0;
  localparam logic [2:0] EN_RESET = 3'h0;
  // Status register fields
  localparam int ST_MEU = 63;
  localparam int ST_MEC = 62;
  localparam int ST_RW = 61;
  localparam int ST_MODA = 59;
  localparam int ST_VCID_LSB = 54;
  localparam int ST_LDWU = 50;
  localparam int ST_LDRU = 48;
  localparam int ST_LDSU = 46;
  localparam int ST_LTC = 45;
  localparam int ST_DIR = 44;
  localparam int ST_LVU = 43;
  localparam int ST_DSC = 38;
  localparam int ST_DSU = 37;
  localparam int ST_VEC = 36;
  localparam int ST_VEU = 35;
  localparam logic [63:0] ST_W1C_MASK = 64'hc03f_fff8_0000_0000;
  localparam logic [63:0] ST_RW_MASK = 64'h2fc0_0000_ffff_ffff;
  // DMA read line shape, way count and trap classes
  localparam int LINE_BYTES = 64;
  localparam int PORTION_BYTES = 4;
  localparam int WAYS = 12;
  localparam logic TRAP_DATA = 1'b1;
  localparam logic TRAP_ECC = 1'b0;

  typedef struct packed {
    logic ldsu;
    logic dsc;
    logic dsu;
    logic rw;
    logic [4:0] vcid;
    logic [31:0] synd;
  } lcel_ev_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] data;
  } lcel_beat_t;

  typedef struct packed {
    logic valid;
    logic cls;
    logic [4:0] strand;
  } lcel_trap_t;

  typedef enum logic [1:0] {
    TAG_IDLE = 2'b01,
    TAG_FIX = 2'b10
  } lcel_tag_st_t;
endpackage

// *** verification/lcel_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module lcel_bank_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wb_valid, wb_ue, wb_valid_out;
  logic wb_poison, dma_rd_last, dmaw_valid, dmaw_ue, dmaw_line_dirty, dmaw_commit;
  logic dmaw_set_dirty, tag_check, tag_fix_done, tag_fix_req, vad_check, dir_scrub, dir_par;
  logic warm_reset_request, debug_trig, rd_err;
  logic [39:0] paddr, err_addr;
  logic [31:0] pwdata, prdata, strand_ceen, strand_nceen, dir_entry, rd_data, last_data;
  logic [4:0] steered_strand_field;
  logic [11:0] tag_ce, tag_hit, vad_valid, vad_alloc, vad_dirty, vad_par;
  lcel_pkg::lcel_ev_t ev;
  lcel_pkg::lcel_beat_t dma_rd_in, dma_rd_out;
  lcel_pkg::lcel_trap_t trap, t_last;
  int fail_count, check_count, n_trap, n_wrr, n_poi, n_derr, n_last, n_com, n_dirty, k, n0;
  int n_dbg;
  localparam logic [39:0] EN = lcel_pkg::EN_OFS;
  localparam logic [39:0] ST = lcel_pkg::ST_OFS;
  localparam logic [39:0] HI = 40'h4;
  localparam logic [31:0] CLR = 32'hc03f_fff8;

  lcel_bank i_lcel_bank (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .steered_strand_field, .strand_ceen, .strand_nceen, .ev, .err_addr, .wb_valid, .wb_ue,
    .wb_valid_out, .wb_poison, .dma_rd_in, .dma_rd_out, .dma_rd_last, .dmaw_valid, .dmaw_ue,
    .dmaw_line_dirty, .dmaw_commit, .dmaw_set_dirty, .tag_check, .tag_ce, .tag_hit,
    .tag_fix_done, .tag_fix_req, .vad_check, .vad_valid, .vad_alloc, .vad_dirty, .vad_par,
    .dir_scrub, .dir_entry, .dir_par, .warm_reset_request, .debug_trig, .trap
  );
  lcel_far i_lcel_far (.pclk, .presetn, .tag_fix_req, .tag_fix_done);

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Pulse counters
  always @(posedge pclk)
  begin
    if (trap.valid === 1'b1)
    begin
      n_trap++;
      t_last = trap;
    end
    n_wrr += int'(warm_reset_request === 1'b1);
    n_poi += int'(wb_poison === 1'b1 && wb_valid_out === 1'b1);
    n_dbg += int'(debug_trig === 1'b1);
    if (dma_rd_last === 1'b1)
      last_data = dma_rd_out.data;
    n_derr += int'(dma_rd_out.valid === 1'b1 && dma_rd_out.err === 1'b1);
    n_last += int'(dma_rd_last === 1'b1);
    n_com += int'(dmaw_commit === 1'b1);
    n_dirty += int'(dmaw_set_dirty === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [39:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [39:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd_data)
  endtask

  task automatic wb_evt;
    @(posedge pclk);
    wb_valid <= 1'b1;
    wb_ue <= 1'b1;
    @(posedge pclk);
    wb_valid <= 1'b0;
    wb_ue <= 1'b0;
    tick(2);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wb_valid, wb_ue, dmaw_valid} = '0;
    {dmaw_ue, dmaw_line_dirty, tag_check, tag_ce, tag_hit, vad_check, vad_valid} = '0;
    {vad_alloc, vad_dirty, vad_par, dir_scrub, dir_entry, dir_par, ev, dma_rd_in} = '0;
    steered_strand_field = 5'h5;
    strand_ceen = 32'hffff_ffff;
    strand_nceen = 32'hffff_ffff;
    err_addr = 40'h12_3456_7890;
    tick(10);
    presetn <= 1'b1;
    apb(1'b1, ST, 32'hffff_ffff);
    apb(1'b1, ST + HI, 32'hffff_ffff);
    apb(1'b1, ST, 32'h0);
    apb(1'b1, ST + HI, 32'h0);
    rd(ST, 32'h0);
    rd(ST + HI, 32'h0);
    rd(EN, 32'h0);
    apb(1'b1, EN, 32'hffff_ffff);
    apb(1'b1, EN + HI, 32'hffff_ffff);
    rd(EN, 32'h7);
    rd(EN + HI, 32'h0);
    rd(40'haa_ffff_ff38, 32'h7);
    rd(lcel_pkg::EN_ALT_OFS, 32'h7);
    rd(EN + 40'h40, 32'h0);
    `CHK("pslverr", 1'b1, rd_err)
    wb_evt();
    `CHK("poison", 1, n_poi)
    `CHK("traps", 1, n_trap)
    `CHK("cls", lcel_pkg::TRAP_DATA, t_last.cls)
    `CHK("strand", 5'h5, t_last.strand)
    rd(ST + HI, 32'h0004_0008);
    rd(lcel_pkg::ADDR_OFS, 32'h3456_7890);
    apb(1'b1, ST + HI, CLR);
    rd(ST + HI, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, EN, (i == 0) ? 32'h1 : 32'h7);
      strand_nceen <= (i == 0) ? 32'hffff_ffff : 32'hffff_ffdf;
      wb_evt();
    end
    `CHK("traps", 1, n_trap)
    `CHK("debug", 2, n_dbg)
    rd(ST + HI, 32'h8004_0008);
    strand_nceen <= 32'hffff_ffff;
    apb(1'b1, ST + HI, CLR);
    for (int b = 0; b < 16; b++)
    begin
      @(posedge pclk);
      dma_rd_in <= '{1'b1, 1'(b == 3 || b == 9), 32'(b)};
    end
    @(posedge pclk);
    dma_rd_in <= '0;
    tick(2);
    `CHK("dma err", 2, n_derr)
    `CHK("dma last", 1, n_last)
    `CHK("last data", 32'h0000_000f, last_data)
    `CHK("traps", 3, n_trap)
    rd(ST + HI, 32'h8001_0008);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      dmaw_valid <= 1'b1;
      dmaw_ue <= (i != 1);
      dmaw_line_dirty <= (i == 2);
      @(posedge pclk);
      {dmaw_valid, dmaw_ue, dmaw_line_dirty} <= 3'h0;
    end
    tick(2);
    `CHK("commit", 1, n_com)
    `CHK("set dirty", 1, n_dirty)
    `CHK("traps", 5, n_trap)
    apb(1'b1, ST + HI, CLR);
    apb(1'b1, ST, 32'h0000_abcd);
    @(posedge pclk);
    tag_check <= 1'b1;
    tag_ce <= 12'h800;
    ev.synd <= 32'h1111_1111;
    @(posedge pclk);
    {tag_check, tag_ce, ev.synd} <= '0;
    @(negedge pclk);
    `CHK("fix req", 1'b1, tag_fix_req)
    k = 0;
    n0 = -1;
    while (tag_fix_req === 1'b1 && k < 50)
    begin
      n0 = n_trap;
      @(negedge pclk);
      k++;
    end
    `CHK("early trap", 5, n0)
    tick(2);
    `CHK("traps", 6, n_trap)
    `CHK("cls", lcel_pkg::TRAP_ECC, t_last.cls)
    rd(ST + HI, 32'h0000_2010);
    rd(ST, 32'h0000_abcd);
    @(posedge pclk);
    tag_check <= 1'b1;
    tag_ce <= 12'h001;
    tag_hit <= 12'h002;
    @(posedge pclk);
    {tag_check, tag_ce, tag_hit} <= '0;
    tick(2);
    `CHK("fix req", 1'b0, tag_fix_req)
    `CHK("traps", 7, n_trap)
    apb(1'b1, ST + HI, CLR);
    @(posedge pclk);
    vad_check <= 1'b1;
    vad_valid <= 12'h001;
    @(posedge pclk);
    {vad_check, vad_valid} <= '0;
    dir_scrub <= 1'b1;
    dir_entry <= 32'h1;
    @(posedge pclk);
    {dir_scrub, dir_entry} <= '0;
    tick(2);
    `CHK("warm reset", 2, n_wrr)
    rd(ST + HI, 32'h8000_1808);
    apb(1'b1, ST + HI, CLR);
    @(posedge pclk);
    ev.dsc <= 1'b1;
    ev.dsu <= 1'b1;
    @(posedge pclk);
    {ev.dsc, ev.dsu} <= 2'h0;
    tick(2);
    rd(ST + HI, 32'h0000_0060);
    apb(1'b1, ST + HI, CLR);
    @(posedge pclk);
    ev <= '{1'b1, 1'b0, 1'b0, 1'b1, 5'h3, 32'h0000_5a5a};
    @(posedge pclk);
    ev <= '0;
    tick(2);
    `CHK("traps", 8, n_trap)
    `CHK("cls", lcel_pkg::TRAP_DATA, t_last.cls)
    rd(ST, 32'h0000_5a5a);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    rd(ST + HI, 32'h20c0_4008);
    rd(EN, 32'h0);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verification/lcel_far.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcel_far #(
  parameter int FIX_CYC = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tag_fix_req,
  output logic tag_fix_done
);
  int cnt;
  // Tag correction ends a fixed time after the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      tag_fix_done <= 1'b0;
    end
    else
    begin
      tag_fix_done <= tag_fix_req && cnt == FIX_CYC - 1;
      cnt <= (tag_fix_req && cnt < FIX_CYC) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/lcel_bank.sv ***
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lcel_bank #(
  parameter logic [1:0] BANK_ID = 2'h0,
  parameter int DIR_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [39:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] steered_strand_field,
  input wire logic [31:0] strand_ceen,
  input wire logic [31:0] strand_nceen,
  input wire lcel_pkg::lcel_ev_t ev,
  input wire logic [39:0] err_addr,
  input wire logic wb_valid,
  input wire logic wb_ue,
  output logic wb_valid_out,
  output logic wb_poison,
  input wire lcel_pkg::lcel_beat_t dma_rd_in,
  output lcel_pkg::lcel_beat_t dma_rd_out,
  output logic dma_rd_last,
  input wire logic dmaw_valid,
  input wire logic dmaw_ue,
  input wire logic dmaw_line_dirty,
  output logic dmaw_commit,
  output logic dmaw_set_dirty,
  input wire logic tag_check,
  input wire logic [11:0] tag_ce,
  input wire logic [11:0] tag_hit,
  input wire logic tag_fix_done,
  output logic tag_fix_req,
  input wire logic vad_check,
  input wire logic [11:0] vad_valid,
  input wire logic [11:0] vad_alloc,
  input wire logic [11:0] vad_dirty,
  input wire logic [11:0] vad_par,
  input wire logic dir_scrub,
  input wire logic [DIR_W-1:0] dir_entry,
  input wire logic dir_par,
  output logic warm_reset_request,
  output logic debug_trig,
  output lcel_pkg::lcel_trap_t trap
);
  localparam int BEATS = lcel_pkg::LINE_BYTES / lcel_pkg::PORTION_BYTES;

  function automatic logic page_is(input logic [39:0] a, input logic [39:0] ofs);
    page_is = (a[39:32] == ofs[39:32]) && (a[7:6] == BANK_ID);
  endfunction

  logic [2:0] en_r;
  logic [63:0] st_r;
  logic [63:0] st_nxt;
  logic [39:0] addr_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  lcel_pkg::lcel_tag_st_t tag_st_r;
  logic [3:0] beat_cnt_r;
  logic [11:0] vad_bad;
  logic ldwu, ldru_rd, ldru_wr, ldru, ltc, lvu, ldir, ue, ce;
  logic ltc_trap, hit_en, hit_st, wr_fire;
  lcel_pkg::lcel_trap_t trap_r;

  // Register decode, bits 31:8 and 5:3 ignored
  assign hit_en = page_is(paddr, lcel_pkg::EN_OFS) | page_is(paddr, lcel_pkg::EN_ALT_OFS);
  assign hit_st = page_is(paddr, lcel_pkg::ST_OFS) | page_is(paddr, lcel_pkg::ST_ALT_OFS);
  assign wr_fire = psel & penable & pready_r & pwrite;

  // Per-way parity, used bit not covered
  genvar gw;
  generate
    for (gw = 0; gw < lcel_pkg::WAYS; gw++)
    begin : g_vad
      assign vad_bad[gw] = ^{vad_valid[gw], vad_alloc[gw], vad_dirty[gw], vad_par[gw]};
    end
  endgenerate

  // Error events
  assign ldwu = wb_valid & wb_ue;
  assign ldru_rd = dma_rd_in.valid & dma_rd_in.err;
  assign ldru_wr = dmaw_valid & dmaw_ue;
  assign ldru = ldru_rd | ldru_wr;
  assign ltc = tag_check & (|tag_ce) & (tag_st_r == lcel_pkg::TAG_IDLE);
  assign lvu = vad_check & (|vad_bad);
  assign ldir = dir_scrub & ((^dir_entry) != dir_par);
  assign ue = ldwu | ldru | ev.ldsu | lvu | ldir;
  assign ce = ltc;
  // Hit with error traps now; otherwise after correction
  assign ltc_trap = (ltc & (|tag_hit)) |
                    ((tag_st_r == lcel_pkg::TAG_FIX) & tag_fix_done);

  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= psel & ~penable & ~pready_r;
      if (psel & ~penable)
      begin
        pslverr_r <= ~(hit_en | hit_st | page_is(paddr, lcel_pkg::ADDR_OFS));
        if (pwrite)
          prdata_r <= 32'h0000_0000;
        else if (hit_en)
          prdata_r <= paddr[2] ? 32'h0000_0000 : {29'h0, en_r};
        else if (hit_st)
          prdata_r <= paddr[2] ? st_r[63:32] : st_r[31:0];
        else if (page_is(paddr, lcel_pkg::ADDR_OFS))
          prdata_r <= paddr[2] ? {24'h0, addr_r[39:32]} : addr_r[31:0];
        else
          prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en_r <= lcel_pkg::EN_RESET;
    else if (wr_fire & hit_en & ~paddr[2])
      en_r <= pwdata[2:0];
  end

  // Status register next value; error fields win over the write
  always_comb
  begin
    logic [63:0] wd;
    logic [63:0] wm;
    wd = paddr[2] ? {pwdata, 32'h0000_0000} : {32'h0000_0000, pwdata};
    wm = paddr[2] ? 64'hffff_ffff_0000_0000 : 64'h0000_0000_ffff_ffff;
    st_nxt = st_r;
    if (wr_fire & hit_st)
    begin
      st_nxt = (st_nxt & ~(wm & lcel_pkg::ST_RW_MASK)) | (wd & wm & lcel_pkg::ST_RW_MASK);
      st_nxt = st_nxt & ~(wd & wm & lcel_pkg::ST_W1C_MASK);
    end
    // Flags set regardless of enables
    if (ldwu)
      st_nxt[lcel_pkg::ST_LDWU] = 1'b1;
    if (ldru)
      st_nxt[lcel_pkg::ST_LDRU] = 1'b1;
    if (ev.ldsu)
      st_nxt[lcel_pkg::ST_LDSU] = 1'b1;
    if (ltc)
      st_nxt[lcel_pkg::ST_LTC] = 1'b1;
    if (ldir)
      st_nxt[lcel_pkg::ST_DIR] = 1'b1;
    if (lvu)
      st_nxt[lcel_pkg::ST_LVU] = 1'b1;
    if (ev.dsc)
      st_nxt[lcel_pkg::ST_DSC] = 1'b1;
    if (ev.dsu)
      st_nxt[lcel_pkg::ST_DSU] = 1'b1;
    if (ue)
    begin
      st_nxt[lcel_pkg::ST_VEU] = 1'b1;
      if (st_r[lcel_pkg::ST_VEU])
        st_nxt[lcel_pkg::ST_MEU] = 1'b1;
      st_nxt[lcel_pkg::ST_RW] = (ldru & ~lvu & ~ldir & ~ev.ldsu & ~ldwu) ? ldru_wr : ev.rw;
      st_nxt[lcel_pkg::ST_MODA] = 1'b0;
      st_nxt[58:54] = ev.vcid;
      st_nxt[31:0] = (lvu | ldir) ? 32'h0000_0000 : ev.synd;
    end
    else if (ce)
    begin
      st_nxt[lcel_pkg::ST_VEC] = 1'b1;
      if (st_r[lcel_pkg::ST_VEC])
        st_nxt[lcel_pkg::ST_MEC] = 1'b1;
      st_nxt[lcel_pkg::ST_RW] = ev.rw;
      st_nxt[lcel_pkg::ST_MODA] = 1'b0;
      st_nxt[58:54] = ev.vcid;
    end
    st_nxt[60] = 1'b0;
    st_nxt[34:32] = 3'h0;
  end

  // No reset: contents survive a reset
  always_ff @(posedge pclk)
  begin
    st_r <= st_nxt;
  end

  // Error address capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      addr_r <= 40'h00_0000_0000;
    else if (ue | ce)
      addr_r <= err_addr;
  end

  // Writeback path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wb_valid_out <= 1'b0;
      wb_poison <= 1'b0;
    end
    else
    begin
      wb_valid_out <= wb_valid;
      wb_poison <= ldwu;
    end
  end

  // DMA read return, one portion per beat
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_rd_out <= '0;
      dma_rd_last <= 1'b0;
      beat_cnt_r <= 4'h0;
    end
    else
    begin
      dma_rd_out <= dma_rd_in;
      dma_rd_last <= dma_rd_in.valid & (beat_cnt_r == 4'(BEATS - 1));
      if (dma_rd_in.valid)
        beat_cnt_r <= beat_cnt_r + 4'h1;
    end
  end

  // Partial DMA write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dmaw_commit <= 1'b0;
      dmaw_set_dirty <= 1'b0;
    end
    else
    begin
      dmaw_commit <= dmaw_valid & ~dmaw_ue;
      dmaw_set_dirty <= ldru_wr & ~dmaw_line_dirty;
    end
  end

  // Tag correction; new tag errors are ignored while pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tag_st_r <= lcel_pkg::TAG_IDLE;
    else
    begin
      case (tag_st_r)
        lcel_pkg::TAG_IDLE:
          if (ltc & ~(|tag_hit))
            tag_st_r <= lcel_pkg::TAG_FIX;
        lcel_pkg::TAG_FIX:
          if (tag_fix_done)
            tag_st_r <= lcel_pkg::TAG_IDLE;
        default:
          tag_st_r <= lcel_pkg::TAG_IDLE;
      endcase
    end
  end

  assign tag_fix_req = (tag_st_r == lcel_pkg::TAG_FIX);

  // Fatal, debug and strand traps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      warm_reset_request <= 1'b0;
      debug_trig <= 1'b0;
      trap_r <= '0;
    end
    else
    begin
      warm_reset_request <= lvu | ldir;
      debug_trig <= en_r[lcel_pkg::EN_DBG] & ue;
      trap_r <= '0;
      trap_r.strand <= steered_strand_field;
      if ((ldwu | ldru | ev.ldsu) & en_r[lcel_pkg::EN_NCEEN] &
          strand_nceen[steered_strand_field])
      begin
        trap_r.valid <= 1'b1;
        trap_r.cls <= lcel_pkg::TRAP_DATA;
      end
      else if (ltc_trap & en_r[lcel_pkg::EN_CEEN] & strand_ceen[steered_strand_field])
      begin
        trap_r.valid <= 1'b1;
        trap_r.cls <= lcel_pkg::TRAP_ECC;
      end
    end
  end

  assign trap = trap_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  en_write_a: assert property (wr_fire && hit_en && !paddr[2] |=>
    en_r == $past(pwdata[2:0])) else $error("enable write lost");
  meu_clear_a: assert property (wr_fire && hit_st && paddr[2] && pwdata[31] && !ue |=>
    !st_r[lcel_pkg::ST_MEU]) else $error("meu not cleared");
  dsc_alone_a: assert property (ev.dsc && !ue && !ce && !st_r[lcel_pkg::ST_VEC] &&
    !(wr_fire && hit_st) |=> !st_r[lcel_pkg::ST_VEC]) else $error("dsc set vec");
  ue_veu_a: assert property (ue |=> st_r[lcel_pkg::ST_VEU] && addr_r == $past(err_addr))
    else $error("veu or address missing");
  wb_poison_a: assert property (wb_valid && wb_ue |=> wb_poison && wb_valid_out)
    else $error("writeback not poisoned");
  ue_trap_a: assert property (ev.ldsu && en_r[lcel_pkg::EN_NCEEN] &&
    strand_nceen[steered_strand_field] |=> trap.valid && trap.cls == lcel_pkg::TRAP_DATA &&
    trap.strand == $past(steered_strand_field)) else $error("data trap missing");
  dmaw_abandon_a: assert property (dmaw_valid && dmaw_ue |=> !dmaw_commit &&
    dmaw_set_dirty == !$past(dmaw_line_dirty)) else $error("partial write not abandoned");
  tag_wait_a: assert property (tag_fix_req && !tag_fix_done |=>
    !(trap.valid && trap.cls == lcel_pkg::TRAP_ECC)) else $error("tag trap too early");
  vad_reset_a: assert property (lvu || ldir |=> warm_reset_request)
    else $error("warm reset missing");
  no_enable_a: assert property (!en_r[lcel_pkg::EN_NCEEN] && !en_r[lcel_pkg::EN_CEEN] |=>
    !trap.valid) else $error("trap without enable");

  fix_cov: cover property (ltc && !(|tag_hit) ##[1:20] tag_fix_done);
  trap_cov: cover property (trap.valid && trap.cls == lcel_pkg::TRAP_DATA);
  line_cov: cover property (dma_rd_last && dma_rd_out.err);
endmodule
`default_nettype wire
